// ### verilog/mii_phy_datapath.sv
`default_nettype none
module mii_phy_datapath (
  input wire logic clock,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic mode_10m,
  input wire logic mode_fiber,
  input wire logic full_duplex,
  input wire logic [3:0] txd,
  input wire logic tx_en,
  input wire logic tx_er,
  output logic [3:0] rxd,
  output logic rx_dv,
  output logic rx_er,
  output logic crs,
  output logic col,
  input wire logic line_rx_in,
  input wire logic line_rx_j,
  input wire logic line_rx_t,
  input wire logic [3:0] line_rx_nib,
  input wire logic line_rx_strobe,
  input wire logic line_rx_err,
  output logic line_rx_ready,
  output logic [3:0] line_tx_out,
  output logic line_tx_en,
  output logic line_tx_er
);
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic lclk;
    logic act;
    logic j;
    logic t;
    logic stb;
    logic err;
    logic tx_en;
    logic tx_er;
    logic [3:0] txd;
    logic [3:0] nib;
    logic m10;
    logic fx;
    logic fdx;
  } pin_t;

  typedef struct packed {
    pin_t s1;
    pin_t s2;
    pin_t s3;
    logic tx_en_q;
    logic tx_er_q;
    logic [3:0] txd_q;
    logic [phy_lat_pkg::TX_PIPE_D-1:0][5:0] pipe;
    logic [3:0] line_tx_out;
    logic line_tx_en;
    logic line_tx_er;
    logic rx_car;
    logic tx_car;
    logic dv_open;
    logic [3:0] rxd;
    logic rx_dv;
    logic rx_dv_d;
    logic rx_er;
    logic crs;
    logic col;
    logic line_rx_ready;
  } st_t;

  st_t s_ff, nxt_s;

  localparam int TW = phy_lat_pkg::TMR_W;
  localparam int NT = phy_lat_pkg::N_TMR;

  logic [NT-1:0] t_start;
  logic [NT-1:0] t_cancel;
  logic [NT-1:0][TW-1:0] t_load;
  logic [NT-1:0] t_done;

  logic lrise, lfall, act_rise, act_fall, j_rise, t_rise, stb_rise;
  logic rx_start, rx_end, txen_rise, txen_fall, m10, fx, fdx;
  logic buf_in_ready, buf_out_valid, buf_pop;
  logic [4:0] buf_out;

  // ---------------------------------------------------------------
  // bit-time to cycle conversion
  // ---------------------------------------------------------------
  // cycles for a delay in bit times, less the fixed path latency
  function automatic logic [TW-1:0] cyc(input int bt, input logic slow);
    int c;
    c = bt * (slow ? phy_lat_pkg::CPB_10 : phy_lat_pkg::CPB_100);
    c = c - phy_lat_pkg::PATH_LAT_CYC;
    if (c < 1) begin
      c = 1;
    end
    return TW'(c);
  endfunction

  // ---------------------------------------------------------------
  // edge and event decode from synchronised pins
  // ---------------------------------------------------------------
  // pin edges are taken between second and third stage only; transmit enable edges from the sampled tx_en_q
  assign m10 = s_ff.s2.m10;
  assign fx = s_ff.s2.fx;
  assign fdx = s_ff.s2.fdx;
  assign lrise = s_ff.s2.lclk & ~s_ff.s3.lclk;
  assign lfall = ~s_ff.s2.lclk & s_ff.s3.lclk;
  assign act_rise = s_ff.s2.act & ~s_ff.s3.act;
  assign act_fall = ~s_ff.s2.act & s_ff.s3.act;
  assign j_rise = s_ff.s2.j & ~s_ff.s3.j;
  assign t_rise = s_ff.s2.t & ~s_ff.s3.t;
  assign stb_rise = s_ff.s2.stb & ~s_ff.s3.stb;
  assign rx_start = m10 ? act_rise : j_rise;
  assign rx_end = m10 ? act_fall : t_rise;
  assign txen_rise = nxt_s.tx_en_q & ~s_ff.tx_en_q;
  assign txen_fall = ~nxt_s.tx_en_q & s_ff.tx_en_q;
  assign buf_pop = lfall & s_ff.dv_open & buf_out_valid;

  // ---------------------------------------------------------------
  // delay timers
  // ---------------------------------------------------------------
  // start, cancel and load of each delay slot
  always_comb begin
    t_start = '0;
    t_cancel = '0;
    t_load = '0;
    // carrier on from J or activity
    t_start[phy_lat_pkg::T_CRS_ON] = rx_start;
    t_cancel[phy_lat_pkg::T_CRS_ON] = rx_end;
    t_load[phy_lat_pkg::T_CRS_ON] = m10 ?
      cyc(phy_lat_pkg::RX10_CRS_ON_BT, 1'b1) :
      cyc(phy_lat_pkg::RX_CRS_ON_BT, 1'b0);
    // carrier or data window off from T or quiet
    t_start[phy_lat_pkg::T_RX_OFF] = rx_end;
    t_cancel[phy_lat_pkg::T_RX_OFF] = rx_start;
    if (m10) begin
      t_load[phy_lat_pkg::T_RX_OFF] =
        cyc(phy_lat_pkg::RX10_DV_OFF_BT, 1'b1);
    end else if (fx) begin
      t_load[phy_lat_pkg::T_RX_OFF] =
        cyc(phy_lat_pkg::RX_CRS_OFF_FX_BT, 1'b0);
    end else begin
      t_load[phy_lat_pkg::T_RX_OFF] =
        cyc(phy_lat_pkg::RX_CRS_OFF_CU_BT, 1'b0);
    end
    // data window opens after carrier
    t_start[phy_lat_pkg::T_DV_ON] = t_done[phy_lat_pkg::T_CRS_ON];
    t_cancel[phy_lat_pkg::T_DV_ON] = rx_end;
    t_load[phy_lat_pkg::T_DV_ON] = m10 ?
      cyc(phy_lat_pkg::RX10_DV_ON_BT, 1'b1) :
      cyc(phy_lat_pkg::RX_DV_ON_BT, 1'b0);
    // slow mode carrier tail after data valid falls
    t_start[phy_lat_pkg::T_TAIL] = m10 & s_ff.rx_dv_d & ~s_ff.rx_dv;
    t_cancel[phy_lat_pkg::T_TAIL] = rx_start;
    t_load[phy_lat_pkg::T_TAIL] =
      TW'(phy_lat_pkg::RX10_CRS_TAIL_CYC);
    // collision on while transmitting half duplex
    t_start[phy_lat_pkg::T_COL_ON] = rx_start & s_ff.tx_en_q & ~fdx;
    t_cancel[phy_lat_pkg::T_COL_ON] = rx_end;
    if (m10) begin
      t_load[phy_lat_pkg::T_COL_ON] =
        cyc(phy_lat_pkg::COL10_ON_BT, 1'b1);
    end else if (fx) begin
      t_load[phy_lat_pkg::T_COL_ON] =
        cyc(phy_lat_pkg::COL_ON_FX_BT, 1'b0);
    end else begin
      t_load[phy_lat_pkg::T_COL_ON] =
        cyc(phy_lat_pkg::COL_ON_CU_BT, 1'b0);
    end
    // collision off from T or quiet
    t_start[phy_lat_pkg::T_COL_OFF] = rx_end;
    t_cancel[phy_lat_pkg::T_COL_OFF] = rx_start;
    if (m10) begin
      t_load[phy_lat_pkg::T_COL_OFF] =
        cyc(phy_lat_pkg::COL10_OFF_BT, 1'b1);
    end else if (fx) begin
      t_load[phy_lat_pkg::T_COL_OFF] =
        cyc(phy_lat_pkg::COL_OFF_FX_BT, 1'b0);
    end else begin
      t_load[phy_lat_pkg::T_COL_OFF] =
        cyc(phy_lat_pkg::COL_OFF_CU_BT, 1'b0);
    end
    // transmit carrier on and off from sampled enable
    t_start[phy_lat_pkg::T_TX_ON] = txen_rise;
    t_cancel[phy_lat_pkg::T_TX_ON] = txen_fall;
    t_start[phy_lat_pkg::T_TX_OFF] = txen_fall;
    t_cancel[phy_lat_pkg::T_TX_OFF] = txen_rise;
    if (m10) begin
      t_load[phy_lat_pkg::T_TX_ON] = cyc(phy_lat_pkg::TX10_CRS_ON_BT, 1'b1);
      t_load[phy_lat_pkg::T_TX_OFF] =
        cyc(phy_lat_pkg::TX10_CRS_OFF_BT, 1'b1);
    end else if (fx) begin
      t_load[phy_lat_pkg::T_TX_ON] =
        cyc(phy_lat_pkg::TX_CRS_ON_FX_BT, 1'b0);
      t_load[phy_lat_pkg::T_TX_OFF] =
        cyc(phy_lat_pkg::TX_CRS_OFF_FX_BT, 1'b0);
    end else begin
      t_load[phy_lat_pkg::T_TX_ON] =
        cyc(phy_lat_pkg::TX_CRS_ON_CU_BT, 1'b0);
      t_load[phy_lat_pkg::T_TX_OFF] =
        cyc(phy_lat_pkg::TX_CRS_OFF_CU_BT, 1'b0);
    end
  end

  // one timer per delay slot
  for (genvar i = 0; i < NT; i++) begin : g_tmr
    bt_timer #(
      .W(TW)
    ) u_tmr (
      .clock(clock),
      .rst(rst),
      .start(t_start[i]),
      .cancel(t_cancel[i]),
      .load(t_load[i]),
      .done(t_done[i])
    );
  end

  // ---------------------------------------------------------------
  // receive nibble buffer
  // ---------------------------------------------------------------
  // holds line nibbles until a falling link clock while the data window is open
  nib_buf #(
    .W(5),
    .DEPTH(phy_lat_pkg::FIFO_DEPTH)
  ) u_buf (
    .clock(clock),
    .rst(rst),
    .in_valid(stb_rise),
    .in_ready(buf_in_ready),
    .in_data({s_ff.s2.err, s_ff.s2.nib}),
    .out_valid(buf_out_valid),
    .out_ready(buf_pop),
    .out_data(buf_out)
  );

  // ---------------------------------------------------------------
  // state update
  // ---------------------------------------------------------------
  // pin sync, transmit sample and pipe, carrier and receive outputs
  always_comb begin
    nxt_s = s_ff;
    nxt_s.s1 = {link_clk, line_rx_in, line_rx_j, line_rx_t,
                line_rx_strobe, line_rx_err, tx_en, tx_er, txd,
                line_rx_nib, mode_10m, mode_fiber, full_duplex};
    nxt_s.s2 = s_ff.s1;
    nxt_s.s3 = s_ff.s2;
    nxt_s.line_rx_ready = buf_in_ready;
    // transmit inputs taken on the rising link clock
    if (lrise) begin
      nxt_s.tx_en_q = s_ff.s2.tx_en;
      nxt_s.tx_er_q = s_ff.s2.tx_er;
      nxt_s.txd_q = s_ff.s2.txd;
    end
    // line output delay line, tapped per medium
    nxt_s.pipe = {s_ff.pipe[phy_lat_pkg::TX_PIPE_D-2:0],
                  {nxt_s.tx_en_q, nxt_s.tx_er_q, nxt_s.txd_q}};
    if (fx) begin
      {nxt_s.line_tx_en, nxt_s.line_tx_er, nxt_s.line_tx_out} =
        s_ff.pipe[phy_lat_pkg::TX_LAT_FX_CYC - 2];
    end else begin
      {nxt_s.line_tx_en, nxt_s.line_tx_er, nxt_s.line_tx_out} =
        s_ff.pipe[phy_lat_pkg::TX_LAT_CU_CYC - 2];
    end
    // transmit carrier
    if (t_done[phy_lat_pkg::T_TX_ON]) begin
      nxt_s.tx_car = 1'b1;
    end else if (t_done[phy_lat_pkg::T_TX_OFF]) begin
      nxt_s.tx_car = 1'b0;
    end
    // receive carrier and data window
    if (t_done[phy_lat_pkg::T_CRS_ON]) begin
      nxt_s.rx_car = 1'b1;
    end
    if (t_done[phy_lat_pkg::T_DV_ON]) begin
      nxt_s.dv_open = 1'b1;
    end
    if (t_done[phy_lat_pkg::T_RX_OFF]) begin
      nxt_s.dv_open = 1'b0;
      if (!m10 || !s_ff.rx_dv) begin
        nxt_s.rx_car = 1'b0;
      end
    end
    if (t_done[phy_lat_pkg::T_TAIL]) begin
      nxt_s.rx_car = 1'b0;
    end
    // collision
    if (t_done[phy_lat_pkg::T_COL_ON]) begin
      nxt_s.col = 1'b1;
    end else if (t_done[phy_lat_pkg::T_COL_OFF] || fdx) begin
      nxt_s.col = 1'b0;
    end
    nxt_s.crs = nxt_s.rx_car | (nxt_s.tx_car & ~fdx);
    // receive outputs change on the falling link clock
    nxt_s.rx_dv_d = s_ff.rx_dv;
    if (lfall) begin
      if (buf_pop) begin
        nxt_s.rx_dv = 1'b1;
        nxt_s.rxd = buf_out[3:0];
        nxt_s.rx_er = buf_out[4];
      end else if (!s_ff.dv_open) begin
        nxt_s.rx_dv = 1'b0;
        nxt_s.rx_er = 1'b0;
        nxt_s.rxd = 4'h0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign rxd = s_ff.rxd;
  assign rx_dv = s_ff.rx_dv;
  assign rx_er = s_ff.rx_er;
  assign crs = s_ff.crs;
  assign col = s_ff.col;
  assign line_rx_ready = s_ff.line_rx_ready;
  assign line_tx_out = s_ff.line_tx_out;
  assign line_tx_en = s_ff.line_tx_en;
  assign line_tx_er = s_ff.line_tx_er;
endmodule // mii_phy_datapath
`default_nettype wire

// ### verilog/phy_lat_pkg.sv
// Summary of operation
// - 100M receive: CRS up 12-16 BT after J
// - 100M copper: CRS down 10-17 BT after T
// - 100M fiber: CRS down 16-22 BT after T
// - 100M: RX_DV data 3-5 BT after CRS
// - copper half duplex: COL up 16-22 BT after J
// - copper: COL down 17-20 BT after T
// - fiber: COL up 10-15 BT after J
// - fiber: COL down 14-18 BT after T
// - copper transmit: CRS up 20-24 BT
// - fiber transmit: CRS up 17-20 BT
// - copper transmit: CRS down 24-28 BT
// - fiber transmit: CRS down 22-24 BT
// - copper: first line symbol 5.3-5.7 BT
// - fiber: first line symbol 5-5.3 BT
// - 10M: line to receive data 4.2-6.6 BT
// - 10M: data and RX_DV 5-32 BT after CRS
// - 10M: CRS down 0.3-0.5 BT after RX_DV
// - 10M: CRS up 2-28 BT after activity
// - 10M: CRS down 6-10 BT after quiet
// - 10M half duplex: COL up 1-31 BT
// - 10M: COL down 5-10 BT after quiet
// - delays counted in 10 or 100 ns bits
`default_nettype none
package phy_lat_pkg;
  // ---------------------------------------------------------------
  // clock and bit times
  // ---------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int BT_100_NS = 10;
  localparam int BT_10_NS = 100;
  localparam int CPB_100 = BT_100_NS / CLK_NS;
  localparam int CPB_10 = BT_10_NS / CLK_NS;
  localparam int PATH_LAT_CYC = 5; // sync, edge and output flops
  localparam int TMR_W = 10;
  // ---------------------------------------------------------------
  // target delays in bit times, or in clock cycles for the CYC ones
  // ---------------------------------------------------------------
  localparam int RX_CRS_ON_BT = 14;
  localparam int RX_CRS_OFF_CU_BT = 13;
  localparam int RX_CRS_OFF_FX_BT = 19;
  localparam int RX_DV_ON_BT = 3;
  localparam int COL_ON_CU_BT = 19;
  localparam int COL_OFF_CU_BT = 18;
  localparam int COL_ON_FX_BT = 12;
  localparam int COL_OFF_FX_BT = 16;
  localparam int TX_CRS_ON_CU_BT = 22;
  localparam int TX_CRS_ON_FX_BT = 18;
  localparam int TX_CRS_OFF_CU_BT = 26;
  localparam int TX_CRS_OFF_FX_BT = 23;
  localparam int TX_LAT_CU_CYC = 6;
  localparam int TX_LAT_FX_CYC = 5;
  localparam int RX10_CRS_ON_BT = 15;
  localparam int RX10_DV_ON_BT = 10;
  localparam int RX10_DV_OFF_BT = 8;
  localparam int RX10_CRS_TAIL_CYC = 4;
  localparam int COL10_ON_BT = 16;
  localparam int COL10_OFF_BT = 7;
  localparam int TX10_CRS_ON_BT = 2;
  localparam int TX10_CRS_OFF_BT = 1;
  // ---------------------------------------------------------------
  // timer slots
  // ---------------------------------------------------------------
  localparam int N_TMR = 8;
  localparam int T_CRS_ON = 0;
  localparam int T_RX_OFF = 1;
  localparam int T_DV_ON = 2;
  localparam int T_TAIL = 3;
  localparam int T_COL_ON = 4;
  localparam int T_COL_OFF = 5;
  localparam int T_TX_ON = 6;
  localparam int T_TX_OFF = 7;
  localparam int TX_PIPE_D = 8;
  localparam int FIFO_DEPTH = 2;
endpackage
`default_nettype wire

// ### verilog/bt_timer.sv
`default_nettype none
module bt_timer #(
  parameter int W = 10
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  input wire logic cancel,
  input wire logic [W-1:0] load,
  output logic done
);
  typedef struct packed {
    logic busy;
    logic [W-1:0] cnt;
    logic done;
  } tmr_t;
  tmr_t s_ff, nxt_s;

  if (W < 2) begin : g_bad_w
    $error("bt_timer: W too small");
  end

  // load on start, count down, pulse done at the end
  always_comb begin
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    if (start) begin
      nxt_s.busy = 1'b1;
      nxt_s.cnt = load;
    end else if (cancel) begin
      nxt_s.busy = 1'b0;
    end else if (s_ff.busy) begin
      if (s_ff.cnt <= W'(1)) begin
        nxt_s.busy = 1'b0;
        nxt_s.done = 1'b1;
      end else begin
        nxt_s.cnt = s_ff.cnt - W'(1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign done = s_ff.done;
endmodule // bt_timer
`default_nettype wire

// ### verilog/nib_buf.sv
`default_nettype none
module nib_buf #(
  parameter int W = 5,
  parameter int DEPTH = 2
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } buf_t;
  buf_t s_ff, nxt_s;
  logic push, pop;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_d
    $error("nib_buf: DEPTH must be a power of two, at least 2");
  end

  // flag and data views of the storage
  assign in_ready = s_ff.cnt != (AW+1)'(DEPTH);
  assign out_valid = s_ff.cnt != '0;
  assign out_data = s_ff.mem[s_ff.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // write at wp, read at rp, count tracks fill
  always_comb begin
    nxt_s = s_ff;
    if (push) begin
      nxt_s.mem[s_ff.wp] = in_data;
      nxt_s.wp = s_ff.wp + AW'(1);
    end
    if (pop) begin
      nxt_s.rp = s_ff.rp + AW'(1);
    end
    if (push && !pop) begin
      nxt_s.cnt = s_ff.cnt + (AW+1)'(1);
    end else if (pop && !push) begin
      nxt_s.cnt = s_ff.cnt - (AW+1)'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule // nib_buf
`default_nettype wire

// ### tb/phy_lat_properties.sv
`default_nettype none
module phy_lat_properties (
  input wire logic clock,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic mode_10m,
  input wire logic mode_fiber,
  input wire logic full_duplex,
  input wire logic tx_en,
  input wire logic crs,
  input wire logic col,
  input wire logic line_rx_in,
  input wire logic line_rx_j,
  input wire logic line_rx_t
);
  timeunit 1ns;
  timeprecision 1ps;
  logic link_q_ff;
  logic tx_smp_ff;
  wire logic lrise = link_clk && !link_q_ff;
  wire logic cu100 = !mode_10m && !mode_fiber;
  wire logic fx100 = !mode_10m && mode_fiber;
  // transmit enable as taken at the last link clock rise
  always_ff @(posedge clock) begin
    link_q_ff <= link_clk;
    if (rst) tx_smp_ff <= 1'b0;
    else if (lrise) tx_smp_ff <= tx_en;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // carrier and collision windows
  // ----------------------------------------
  property p_rx_crs_on;
    $rose(line_rx_j) && !mode_10m && !crs |-> ##[12:16] $rose(crs);
  endproperty
  a_rx_crs_on: assert property (p_rx_crs_on)
    else $error("receive carrier rise out of window");
  property p_crs_off_cu;
    $rose(line_rx_t) && cu100 && crs && !tx_smp_ff |-> ##[10:17] $fell(crs);
  endproperty
  a_crs_off_cu: assert property (p_crs_off_cu)
    else $error("copper carrier fall out of window");
  property p_crs_off_fx;
    $rose(line_rx_t) && fx100 && crs && !tx_smp_ff |-> ##[16:22] $fell(crs);
  endproperty
  a_crs_off_fx: assert property (p_crs_off_fx)
    else $error("fiber carrier fall out of window");
  property p_col_on_cu;
    $rose(line_rx_j) && cu100 && tx_smp_ff && !full_duplex && !col
      |-> ##[16:22] $rose(col);
  endproperty
  a_col_on_cu: assert property (p_col_on_cu)
    else $error("copper collision rise out of window");
  property p_col_off_cu;
    $rose(line_rx_t) && cu100 && col |-> ##[17:20] $fell(col);
  endproperty
  a_col_off_cu: assert property (p_col_off_cu)
    else $error("copper collision fall out of window");
  property p_col_on_fx;
    $rose(line_rx_j) && fx100 && tx_smp_ff && !full_duplex && !col
      |-> ##[10:15] $rose(col);
  endproperty
  a_col_on_fx: assert property (p_col_on_fx)
    else $error("fiber collision rise out of window");
  property p_tx_crs_cu;
    lrise && tx_en && !tx_smp_ff && cu100 && !full_duplex && !crs
      |-> ##[20:24] $rose(crs);
  endproperty
  a_tx_crs_cu: assert property (p_tx_crs_cu)
    else $error("transmit carrier rise out of window");
  property p_quiet_10m;
    $fell(line_rx_in) && mode_10m && crs && !tx_smp_ff
      |-> ##[60:100] $fell(crs);
  endproperty
  a_quiet_10m: assert property (p_quiet_10m)
    else $error("ten megabit carrier fall out of window");
  c_rx: cover property ($rose(crs) && !mode_10m);
  c_col: cover property ($rose(col));
  c_q10: cover property ($fell(crs) && mode_10m);
endmodule // phy_lat_properties
bind mii_phy_datapath phy_lat_properties u_props (
  .clock(clock), .rst(rst), .link_clk(link_clk), .mode_10m(mode_10m),
  .mode_fiber(mode_fiber), .full_duplex(full_duplex), .tx_en(tx_en),
  .crs(crs), .col(col), .line_rx_in(line_rx_in), .line_rx_j(line_rx_j),
  .line_rx_t(line_rx_t)
);
`default_nettype wire

// ### tb/mac_model.sv
`default_nettype none
module mac_model (
  input wire logic link_clk,
  input wire logic [3:0] rxd,
  input wire logic rx_dv,
  input wire logic rx_er,
  output logic [3:0] txd,
  output logic tx_en,
  output logic tx_er
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] rx_q[$];
  bit busy;
  // idle transmit side
  initial begin
    txd = 4'h0;
    tx_en = 1'b0;
    tx_er = 1'b0;
    busy = 1'b0;
  end
  // receive nibbles taken at the link clock rise
  always @(posedge link_clk) begin
    if (rx_dv === 1'b1) rx_q.push_back({rx_er, rxd});
  end
  // one frame, changed away from the sampling rise
  task automatic send(input logic [3:0] d[$]);
    busy = 1'b1;
    foreach (d[i]) begin
      @(negedge link_clk);
      tx_en <= 1'b1;
      txd <= d[i];
    end
    @(negedge link_clk);
    tx_en <= 1'b0;
    txd <= ~txd; // idle data does not hold the last nibble
    busy = 1'b0;
  endtask
endmodule // mac_model
`default_nettype wire

// ### tb/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst, link_clk, mode_10m, mode_fiber, full_duplex;
  logic [3:0] txd, rxd, line_rx_nib, line_tx_out;
  logic tx_en, tx_er, rx_dv, rx_er, crs, col, line_rx_in, line_rx_j;
  logic line_rx_t, line_rx_strobe, line_rx_err, line_rx_ready;
  logic line_tx_en, line_tx_er;
  int err_count, tests_run, n;
  integer seed = 32'h8eab9835;
  int crs_lo[3] = '{12, 12, 2};
  int crs_hi[3] = '{16, 16, 28};
  int col_lo[3] = '{16, 10, 1};
  int col_hi[3] = '{22, 15, 31};
  logic [4:0] exp_q[$];
  logic [3:0] tx_q[$];

  mii_phy_datapath u_dut (
    .clock(clock), .rst(rst), .link_clk(link_clk), .mode_10m(mode_10m),
    .mode_fiber(mode_fiber), .full_duplex(full_duplex), .txd(txd),
    .tx_en(tx_en), .tx_er(tx_er), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er),
    .crs(crs), .col(col), .line_rx_in(line_rx_in), .line_rx_j(line_rx_j),
    .line_rx_t(line_rx_t), .line_rx_nib(line_rx_nib),
    .line_rx_strobe(line_rx_strobe), .line_rx_err(line_rx_err),
    .line_rx_ready(line_rx_ready), .line_tx_out(line_tx_out),
    .line_tx_en(line_tx_en), .line_tx_er(line_tx_er)
  );
  mac_model u_mac (
    .link_clk(link_clk), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er),
    .txd(txd), .tx_en(tx_en), .tx_er(tx_er)
  );
  // system clock and a free link clock of unrelated phase
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    link_clk = 1'b0;
    #37;
    forever #80 link_clk = ~link_clk;
  end
  // ----------------------------------------
  // checking and driving helpers
  // ----------------------------------------
  task automatic results();
    if (err_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk_eq(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_in(input int got, input int lo, input int hi);
    tests_run++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  function automatic int cyc(input int m, input int bt);
    return bt * (m == 2 ? 10 : 1);
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  // counts cycles until an output reaches a level
  task automatic wait_on(input int sel, input logic v, output int c);
    logic s;
    c = 0;
    s = ~v;
    while (s !== v) begin
      tick(1);
      c++;
      case (sel)
        0: s = crs;
        1: s = col;
        2: s = line_tx_en;
        default: s = line_rx_ready;
      endcase
      if (c > 600) begin
        err_count++;
        results();
      end
    end
  endtask
  // one nibble into the line buffer; kept ones are expected back
  task automatic push(input bit keep);
    logic [4:0] v;
    v = 5'($random(seed));
    line_rx_nib = v[3:0];
    line_rx_err = v[4];
    tick(1);
    line_rx_strobe = 1'b1;
    tick(3);
    line_rx_strobe = 1'b0;
    tick(3);
    line_rx_nib = ~v[3:0];
    if (keep) exp_q.push_back(v);
  endtask
  task automatic idle_mac();
    int k;
    k = 0;
    while (u_mac.busy && k < 3000) begin
      tick(1);
      k++;
    end
    if (u_mac.busy) begin
      err_count++;
      results();
    end
    tick(400);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // receive frame; m 0 copper, 1 fiber, 2 ten megabit
  task automatic rx_frame(input int m, input bit wt, input bit fdx);
    mode_10m = (m == 2);
    mode_fiber = (m == 1);
    full_duplex = fdx;
    exp_q.delete();
    u_mac.rx_q.delete();
    tick(40);
    if (wt) begin
      tx_q.delete();
      repeat (90) tx_q.push_back(4'($random(seed)));
      fork u_mac.send(tx_q); join_none
      tick(60);
    end
    push(1);
    push(1);
    tick(4);
    chk_eq(line_rx_ready, 0);
    push(0); // buffer full, nibble refused
    if (m == 2) line_rx_in = 1'b1;
    else line_rx_j = 1'b1;
    if (!wt) begin
      wait_on(0, 1'b1, n);
      chk_in(n, cyc(m, crs_lo[m]), cyc(m, crs_hi[m]) + 1);
    end else if (!fdx) begin
      wait_on(1, 1'b1, n);
      chk_in(n, cyc(m, col_lo[m]), cyc(m, col_hi[m]) + 1);
    end else begin
      tick(40);
      chk_eq(col, 0);
    end
    line_rx_j = 1'b0;
    repeat (6) begin
      wait_on(3, 1'b1, n);
      push(1);
    end
    n = 0;
    while (u_mac.rx_q.size() < 8 && n < 3000) begin
      tick(1);
      n++;
    end
    foreach (exp_q[i]) chk_eq(u_mac.rx_q[i], exp_q[i]);
    if (m == 2) line_rx_in = 1'b0;
    else line_rx_t = 1'b1;
    tick(8);
    line_rx_t = 1'b0;
    tick(200);
    if (!wt) chk_eq({crs, col, rx_dv}, 0);
    else chk_eq(col, 0);
    idle_mac();
  endtask
  // transmit frame: first line symbol and its delay
  task automatic tx_frame(input int m);
    int lat;
    lat = m ? phy_lat_pkg::TX_LAT_FX_CYC : phy_lat_pkg::TX_LAT_CU_CYC;
    mode_10m = 1'b0;
    mode_fiber = (m == 1);
    full_duplex = 1'b0;
    tx_q.delete();
    repeat (6) tx_q.push_back(4'($random(seed)));
    tick(40);
    fork u_mac.send(tx_q); join_none
    @(negedge link_clk);
    @(posedge link_clk);
    wait_on(2, 1'b1, n);
    chk_in(n, lat + 2, lat + 5);
    chk_eq(line_tx_out, tx_q[0]);
    idle_mac();
    chk_eq({crs, line_tx_en}, 0);
  endtask
  // reset, then every mode for receive and collision, copper and fiber for transmit
  initial begin
    err_count = 0;
    tests_run = 0;
    rst = 1'b1;
    {mode_10m, mode_fiber, full_duplex, line_rx_in, line_rx_j} = '0;
    {line_rx_t, line_rx_strobe, line_rx_err} = '0;
    line_rx_nib = 4'h0;
    tick(2);
    rst = 1'b0;
    tick(1);
    chk_eq({rxd, rx_dv, rx_er, crs, col}, 0);
    tick(3);
    chk_eq({line_tx_out, line_tx_en, line_tx_er, line_rx_ready}, 8'h01);
    for (int m = 0; m < 3; m++) rx_frame(m, 0, 0);
    for (int m = 0; m < 3; m++) rx_frame(m, 1, 0);
    rx_frame(0, 1, 1);
    for (int m = 0; m < 2; m++) tx_frame(m);
    results();
  end
endmodule // tb
`default_nettype wire
